// >>> debsc_defs.vh
`ifndef DEBSC_DEFS_VH
`define DEBSC_DEFS_VH

// Register byte offsets
`define DEBSC_OFS_CTL       5'h00
`define DEBSC_OFS_STAT      5'h04
`define DEBSC_OFS_IRQ_STAT  5'h08
`define DEBSC_OFS_IRQ_EN    5'h0c
`define DEBSC_OFS_IRQ_CLR   5'h10
`define DEBSC_OFS_DEFVAL    5'h14
`define DEBSC_ADDR_W        4'd5

// Display control register fields
`define DEBSC_CTL_CHANNEL_RESET_BIT     31
`define DEBSC_CTL_BLK       30
`define DEBSC_CTL_LOCK      28
`define DEBSC_CTL_FSEL      23
`define DEBSC_CTL_VSEL      22
`define DEBSC_CTL_EN        15
`define DEBSC_CTL_DVEN      11
`define DEBSC_CTL_RAW       2
`define DEBSC_CTL_RESET     32'h40000000
// Bits software may write while the display is enabled
`define DEBSC_CTL_LIVE_MASK 32'h40008000
// Writable bits: 30, 28, 23, 22, 15, 11, 2..0
`define DEBSC_CTL_WR_MASK   32'h50c08807

// Display status register fields
`define DEBSC_ST_FRM        30
`define DEBSC_ST_F2         29
`define DEBSC_ST_F1         28

// Interrupt bits
`define DEBSC_IRQ_F1        0
`define DEBSC_IRQ_F2        1
`define DEBSC_IRQ_FRM       2

// Timing
`define DEBSC_PIX_DIV       4'd4
`define DEBSC_H_TOTAL       12'd858
`define DEBSC_H_ACTIVE      12'd720
`define DEBSC_V_TOTAL       12'd262
`define DEBSC_V_BLANK       12'd20
`define DEBSC_VSYNC_LINES   12'd3
`define DEBSC_FIFO_THRESH   8'd64
`define DEBSC_BLANK_VAL     8'h80
`define DEBSC_DEFVAL_RESET  8'h10

`endif

// >>> debsc_timing.v
`timescale 1ns/1ps
`default_nettype none
`include "debsc_defs.vh"

module debsc_timing #(
  parameter [11:0] H_TOTAL = `DEBSC_H_TOTAL,
  parameter [11:0] V_TOTAL = `DEBSC_V_TOTAL
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        restart,
  input  wire        ext_field_en,
  input  wire        ext_field,
  output reg  [11:0] h_q,
  output reg  [11:0] v_q,
  output reg         field_q,
  output reg         line_start_q,
  output reg         frame_start_q,
  output reg         f1_done_q,
  output reg         f2_done_q
);

  always @(posedge clk) begin
    if (rst) begin
      h_q           <= 12'h000;
      v_q           <= 12'h000;
      field_q       <= 1'b0;
      line_start_q  <= 1'b0;
      frame_start_q <= 1'b0;
      f1_done_q     <= 1'b0;
      f2_done_q     <= 1'b0;
    end else begin
      line_start_q  <= 1'b0;
      frame_start_q <= 1'b0;
      f1_done_q     <= 1'b0;
      f2_done_q     <= 1'b0;
      if (restart) begin
        h_q           <= 12'h000;
        v_q           <= 12'h000;
        field_q       <= ext_field_en ? ext_field : 1'b0;
        frame_start_q <= 1'b1;
        line_start_q  <= 1'b1;
      end else if (ce) begin
        if (h_q == H_TOTAL - 12'd1) begin
          h_q          <= 12'h000;
          line_start_q <= 1'b1;
          if (v_q == V_TOTAL - 12'd1) begin
            v_q       <= 12'h000;
            f1_done_q <= ~field_q;
            f2_done_q <= field_q;
            frame_start_q <= field_q;
            field_q   <= ext_field_en ? ext_field : ~field_q;
          end else begin
            v_q <= v_q + 12'd1;
            if (ext_field_en)
              field_q <= ext_field;
          end
        end else begin
          h_q <= h_q + 12'd1;
          if (ext_field_en)
            field_q <= ext_field;
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> debsc_top.v
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "debsc_defs.vh"

module debsc_top #(
  parameter [3:0]  PIX_DIV     = `DEBSC_PIX_DIV,
  parameter [11:0] H_TOTAL     = `DEBSC_H_TOTAL,
  parameter [11:0] H_ACTIVE    = `DEBSC_H_ACTIVE,
  parameter [11:0] V_TOTAL     = `DEBSC_V_TOTAL,
  parameter [11:0] V_BLANK     = `DEBSC_V_BLANK,
  parameter [11:0] VSYNC_LINES = `DEBSC_VSYNC_LINES,
  parameter [7:0]  FIFO_THRESH = `DEBSC_FIFO_THRESH
) (
  input  wire        MCLK,
  input  wire        RST,
  input  wire [4:0]  ADDR,
  input  wire [31:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [31:0] RDATA,
  output reg         IRQ,
  input  wire        PRIOR_FRAME_START,
  input  wire [7:0]  FIFO_LEVEL,
  input  wire [7:0]  FIFO_DATA,
  output reg         FIFO_POP,
  output reg         FIFO_FLUSH,
  output reg         DMA_EVENT,
  output reg  [7:0]  VOUT,
  input  wire        CTL2_I,
  output reg         CTL2_O,
  output reg         CTL2_OE,
  input  wire        CTL3_I,
  output reg         CTL3_O,
  output reg         CTL3_OE
);

  reg  [31:0] ctl_q;
  reg  [31:0] ctl_d;
  reg         channel_reset_bit_q;
  reg  [2:0]  done_q;
  reg  [2:0]  irq_stat_q;
  reg  [2:0]  irq_en_q;
  reg  [7:0]  defval_q;
  reg  [3:0]  div_q;
  reg         pix_ce_q;
  reg         events_on_q;
  reg         v_s1_q;
  reg         v_s2_q;
  reg         v_s3_q;
  reg         f_s1_q;
  reg         f_s2_q;
  reg  [7:0]  pix_d;
  reg         pop_d;

  wire        srst = RST | channel_reset_bit_q;
  wire        wr_ctl = WR & (ADDR == `DEBSC_OFS_CTL);
  wire        wr_stat = WR & (ADDR == `DEBSC_OFS_STAT);
  wire        wr_clr = WR & (ADDR == `DEBSC_OFS_IRQ_CLR);
  wire        en = ctl_q[`DEBSC_CTL_EN];
  wire        blk = ctl_q[`DEBSC_CTL_BLK];
  wire        fsel = ctl_q[`DEBSC_CTL_FSEL];
  wire        vsel = ctl_q[`DEBSC_CTL_VSEL];
  wire        bt656 = ~ctl_q[`DEBSC_CTL_RAW];

  wire [11:0] h_cnt;
  wire [11:0] v_cnt;
  wire        field;
  wire        line_start;
  wire        frame_start;
  wire        f1_done;
  wire        f2_done;
  wire [2:0]  done_ev = {frame_start & en & (v_cnt == 12'h000) & ~field,
                         f2_done, f1_done};
  wire        restart = en & ((vsel & v_s2_q & ~v_s3_q) |
                              (ctl_q[`DEBSC_CTL_LOCK] & PRIOR_FRAME_START));
  wire        vblank = v_cnt < V_BLANK;
  wire        active = (h_cnt < H_ACTIVE) & ~vblank;
  wire [11:0] eav_off = h_cnt - H_ACTIVE;
  wire [11:0] sav_off = h_cnt - (H_TOTAL - 12'd4);
  wire        in_eav = (h_cnt >= H_ACTIVE) & (h_cnt < H_ACTIVE + 12'd4);
  wire        in_sav = h_cnt >= H_TOTAL - 12'd4;

  // Counters keep running while events are blocked
  debsc_timing #(
    .H_TOTAL (H_TOTAL),
    .V_TOTAL (V_TOTAL)
  ) u_timing (
    .clk           (MCLK),
    .rst           (srst | ~en),
    .ce            (pix_ce_q),
    .restart       (restart),
    .ext_field_en  (fsel),
    .ext_field     (f_s2_q),
    .h_q           (h_cnt),
    .v_q           (v_cnt),
    .field_q       (field),
    .line_start_q  (line_start),
    .frame_start_q (frame_start),
    .f1_done_q     (f1_done),
    .f2_done_q     (f2_done)
  );

  // Timing reference byte: 1 F V H P3 P2 P1 P0
  function [7:0] ref_code;
    input f;
    input v;
    input h;
    begin
      ref_code = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    end
  endfunction

  function [7:0] ref_byte;
    input [1:0] idx;
    input [7:0] code;
    begin
      case (idx)
        2'd0: ref_byte = 8'hff;
        2'd3: ref_byte = code;
        default: ref_byte = 8'h00;
      endcase
    end
  endfunction

  always @* begin
    ctl_d = ctl_q;
    if (wr_ctl) begin
      if (en)
        ctl_d = (ctl_q & ~`DEBSC_CTL_LIVE_MASK) |
                (WDATA & `DEBSC_CTL_LIVE_MASK);
      else
        ctl_d = WDATA & `DEBSC_CTL_WR_MASK;
    end
  end

  always @(posedge MCLK) begin
    if (srst) begin
      ctl_q <= `DEBSC_CTL_RESET;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // Channel reset stands one cycle, then resets every register of the module except RDATA and the channel reset bit itself
  always @(posedge MCLK) begin
    if (RST) begin
      channel_reset_bit_q <= 1'b0;
    end else begin
      channel_reset_bit_q <= wr_ctl & WDATA[`DEBSC_CTL_CHANNEL_RESET_BIT] & ~channel_reset_bit_q;
    end
  end

  always @(posedge MCLK) begin
    if (srst) begin
      div_q    <= 4'h0;
      pix_ce_q <= 1'b0;
    end else if (div_q == PIX_DIV - 4'd1) begin
      div_q    <= 4'h0;
      pix_ce_q <= 1'b1;
    end else begin
      div_q    <= div_q + 4'd1;
      pix_ce_q <= 1'b0;
    end
  end

  // Sync input pins
  always @(posedge MCLK) begin
    if (srst) begin
      v_s1_q <= 1'b0;
      v_s2_q <= 1'b0;
      v_s3_q <= 1'b0;
      f_s1_q <= 1'b0;
      f_s2_q <= 1'b0;
    end else begin
      v_s1_q <= CTL2_I;
      v_s2_q <= v_s1_q;
      v_s3_q <= v_s2_q;
      f_s1_q <= CTL3_I;
      f_s2_q <= f_s1_q;
    end
  end

  // Events stay off after unblocking until the next frame begins
  always @(posedge MCLK) begin
    if (srst) begin
      events_on_q <= 1'b0;
      FIFO_FLUSH  <= 1'b0;
      DMA_EVENT   <= 1'b0;
    end else begin
      FIFO_FLUSH <= ctl_d[`DEBSC_CTL_BLK] & ~blk;
      if (blk | ~en)
        events_on_q <= 1'b0;
      else if (frame_start)
        events_on_q <= 1'b1;
      DMA_EVENT <= events_on_q & ~blk & line_start &
                   (FIFO_LEVEL < FIFO_THRESH);
    end
  end

  always @* begin
    pix_d = `DEBSC_BLANK_VAL;
    pop_d = 1'b0;
    if (bt656 & in_eav)
      pix_d = ref_byte(eav_off[1:0], ref_code(field, vblank, 1'b1));
    else if (bt656 & in_sav)
      pix_d = ref_byte(sav_off[1:0], ref_code(field, vblank, 1'b0));
    else if (active) begin
      if (events_on_q & (FIFO_LEVEL != 8'h00)) begin
        pix_d = FIFO_DATA;
        pop_d = 1'b1;
      end else if (ctl_q[`DEBSC_CTL_DVEN])
        pix_d = defval_q;
    end
  end

  always @(posedge MCLK) begin
    if (srst) begin
      VOUT     <= `DEBSC_BLANK_VAL;
      FIFO_POP <= 1'b0;
    end else begin
      FIFO_POP <= pix_ce_q & en & pop_d;
      if (pix_ce_q & en)
        VOUT <= pix_d;
    end
  end

  // Control pins drive sync out only when not selected as inputs
  always @(posedge MCLK) begin
    if (srst) begin
      CTL2_O  <= 1'b0;
      CTL2_OE <= 1'b0;
      CTL3_O  <= 1'b0;
      CTL3_OE <= 1'b0;
    end else begin
      CTL2_O  <= en & (v_cnt < VSYNC_LINES);
      CTL2_OE <= en & ~vsel;
      CTL3_O  <= en & field;
      CTL3_OE <= en & ~fsel;
    end
  end

  // Done flags and interrupt status: a new event beats a clear
  always @(posedge MCLK) begin
    if (srst) begin
      done_q     <= 3'h0;
      irq_stat_q <= 3'h0;
      irq_en_q   <= 3'h0;
      defval_q   <= `DEBSC_DEFVAL_RESET;
      IRQ        <= 1'b0;
    end else begin
      done_q <= done_ev |
                (done_q & ~({3{wr_stat}} & WDATA[30:28]));
      irq_stat_q <= done_ev |
                    (irq_stat_q & ~({3{wr_clr}} & WDATA[2:0]));
      if (WR & (ADDR == `DEBSC_OFS_IRQ_EN))
        irq_en_q <= WDATA[2:0];
      if (WR & (ADDR == `DEBSC_OFS_DEFVAL))
        defval_q <= WDATA[7:0];
      IRQ <= |(irq_stat_q & irq_en_q);
    end
  end

  always @(posedge MCLK) begin
    if (RST) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      case (ADDR)
        `DEBSC_OFS_CTL:
          RDATA <= ctl_q | {channel_reset_bit_q, 31'h00000000};
        `DEBSC_OFS_STAT:
          RDATA <= {1'b0, done_q, v_cnt, 2'b00, vblank, field, h_cnt};
        `DEBSC_OFS_IRQ_STAT:
          RDATA <= {29'h00000000, irq_stat_q};
        `DEBSC_OFS_IRQ_EN:
          RDATA <= {29'h00000000, irq_en_q};
        `DEBSC_OFS_DEFVAL:
          RDATA <= {24'h000000, defval_q};
        default:
          RDATA <= 32'h00000000;
      endcase
    end else begin
      RDATA <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// >>> debsc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module debsc_monitor (
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic [4:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        IRQ,
  input wire logic [7:0]  FIFO_LEVEL,
  input wire logic        FIFO_POP,
  input wire logic        FIFO_FLUSH,
  input wire logic        DMA_EVENT,
  input wire logic        CTL2_OE,
  input wire logic        CTL3_OE
);
  logic       en_q, fs_q, vs_q, blk_q, rc_q;
  logic [2:0] ien_q;
  wire        cw = WR && ADDR == 5'h00;
  // Shadow of the control bits; selects only move while disabled
  always @(posedge MCLK) begin
    rc_q <= cw && WDATA[31];
    if (RST || rc_q) begin
      {en_q, fs_q, vs_q, blk_q, ien_q} <= 7'h08;
    end else begin
      if (cw) begin
        blk_q <= WDATA[30];
        en_q <= WDATA[15];
        if (!en_q)
          {fs_q, vs_q} <= WDATA[23:22];
      end
      if (WR && ADDR == 5'h0c)
        ien_q <= WDATA[2:0];
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_block_set;
    cw && WDATA[30] && !blk_q;
  endsequence
  sequence s_flush_pulse;
    FIFO_FLUSH ##1 !FIFO_FLUSH;
  endsequence
  property p_flush;
    s_block_set |=> s_flush_pulse;
  endproperty
  property p_blk;
    blk_q && $past(blk_q) && $past(blk_q, 2) |-> !DMA_EVENT && !FIFO_POP;
  endproperty
  property p_oe2;
    $stable(en_q && !vs_q) |-> CTL2_OE == (en_q && !vs_q);
  endproperty
  property p_oe3;
    $stable(en_q && !fs_q) |-> CTL3_OE == (en_q && !fs_q);
  endproperty
  property p_rsv;
    $past(RD && ADDR == 5'h00) |-> RDATA[29] == 1'b0 && RDATA[27:24] == 4'h0;
  endproperty
  property p_irq;
    IRQ |-> $past(ien_q) != 3'h0;
  endproperty
  property p_dlvl;
    DMA_EVENT |-> $past(FIFO_LEVEL) < 8'h40;
  endproperty
  property p_rdz;
    !$past(RD) |-> RDATA == 32'h0;
  endproperty
  a_flush: assert property (p_flush) else $error("flush pulse wrong");
  a_blk: assert property (p_blk) else $error("event while blocked");
  a_oe2: assert property (p_oe2) else $error("pin two enable");
  a_oe3: assert property (p_oe3) else $error("pin three enable");
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  a_irq: assert property (p_irq) else $error("irq while masked");
  a_dlvl: assert property (p_dlvl) else $error("event at high level");
  a_rdz: assert property (p_rdz) else $error("stray read data");
endmodule
bind debsc_top debsc_monitor u_mon (.MCLK(MCLK), .RST(RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
  .FIFO_LEVEL(FIFO_LEVEL), .FIFO_POP(FIFO_POP), .FIFO_FLUSH(FIFO_FLUSH),
  .DMA_EVENT(DMA_EVENT), .CTL2_OE(CTL2_OE), .CTL3_OE(CTL3_OE));
`default_nettype wire

// >>> debsc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module debsc_partner (
  input  wire logic       clk,
  input  wire logic       pop,
  input  wire logic       flush,
  input  wire logic       dma,
  input  wire logic       oe2,
  input  wire logic       o2,
  input  wire logic       oe3,
  input  wire logic       o3,
  output var  logic [7:0] lvl,
  output var  logic [7:0] dat,
  output wire logic       c2,
  output wire logic       c3
);
  logic [8:0] t = 9'h0;
  initial lvl = 8'h0;
  initial dat = 8'h0;
  // Outside sync source drives a pin only while the port listens
  assign c2 = oe2 ? o2 : (t < 9'h3);
  assign c3 = oe3 ? o3 : t[8];
  always @(posedge clk) begin
    t <= t + 9'h1;
    if (flush)
      lvl <= 8'h0;
    else if (dma)
      lvl <= lvl + 8'h10;
    else if (pop && lvl != 8'h0)
      lvl <= lvl - 8'h1;
    if (pop)
      dat <= dat + 8'h1;
  end
endmodule
`default_nettype wire

// >>> test_display_event_block_sync_ctl.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin \
  num_checks++; \
  if ((s) !== (e)) begin \
    n_fail++; \
    $display("MISMATCH %s exp %h got %h", nm, e, s); \
  end \
end
module test_display_event_block_sync_ctl;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pfs = 1'b0;
  logic [4:0]  addr = 5'h0;
  logic [31:0] wdata = 32'h0, rdata, r;
  logic [7:0]  lvl, dat, vout;
  logic        irq, pop, fl, dma, c2o, c2e, c3o, c3e, c2i, c3i;
  logic        rd_d = 1'b0;
  logic [63:0] q[$];
  logic [63:0] e;
  int          n_fail = 0, num_checks = 0, seed = 77, i, n;
  int          nd = 0, nf = 0, nv = 0, n3 = 0;
  wire  [1:0]  ev = {dma, irq};
  always #5 clk = ~clk;
  debsc_top #(.H_TOTAL(12'd16), .H_ACTIVE(12'd8), .V_TOTAL(12'd4),
    .V_BLANK(12'd1)) dut (.MCLK(clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
    .PRIOR_FRAME_START(pfs), .FIFO_LEVEL(lvl), .FIFO_DATA(dat),
    .FIFO_POP(pop), .FIFO_FLUSH(fl), .DMA_EVENT(dma), .VOUT(vout),
    .CTL2_I(c2i), .CTL2_O(c2o), .CTL2_OE(c2e), .CTL3_I(c3i),
    .CTL3_O(c3o), .CTL3_OE(c3e));
  debsc_partner far (.clk(clk), .pop(pop), .flush(fl), .dma(dma),
    .oe2(c2e), .o2(c2o), .oe3(c3e), .o3(c3o), .lvl(lvl), .dat(dat),
    .c2(c2i), .c3(c3i));
  task automatic wr32(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd32(input logic [4:0] a, input logic [31:0] m, x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    q.push_back({m, x & m});
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic waitfor(input int k, input int lim);
    for (n = 0; n < lim && ev[k] !== 1'b1; n++)
      @(posedge clk);
    `CHK("wait", 1'b1, ev[k])
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_d) begin
      e = q.pop_front();
      `CHK("rdata", e[31:0], rdata & e[63:32])
    end
    rd_d <= rd;
  end
  initial begin
    #100000;
    n_fail++;
    results();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd32(5'h00, 32'hffffffff, 32'h40000000);
    rd32(5'h1c, 32'hffffffff, 32'h0);
    wr32(5'h00, 32'h7fffffff);
    rd32(5'h00, 32'hffffffff, 32'h50c08807);
    wr32(5'h00, 32'h0);
    rd32(5'h00, 32'hffffffff, 32'h10c00807);
    for (i = 0; i < 6; i++) begin
      r = $random(seed) & 32'h7fff7fff;
      wr32(5'h00, r);
      rd32(5'h00, 32'hffffffff, r & 32'h50c08807);
    end
    wr32(5'h00, 32'h40008800);
    repeat (3) @(posedge clk);
    `CHK("pin_oe", 2'b11, {c2e, c3e})
    wr32(5'h0c, 32'h4);
    wr32(5'h14, 32'h5a);
    // One whole frame while blocked: counts repeat every frame
    repeat (512) begin
      @(posedge clk);
      nd += (vout === 8'h5a);
      nf += (vout === 8'hff);
      nv += (c2o === 1'b1);
      n3 += (c3o === 1'b1);
    end
    `CHK("defval", 192, nd)
    `CHK("ref_ff", 64, nf)
    `CHK("vsync", 384, nv)
    `CHK("field", 256, n3)
    waitfor(0, 1200);
    rd32(5'h04, 32'h40000000, 32'h40000000);
    wr32(5'h04, 32'h0);
    rd32(5'h04, 32'h40000000, 32'h40000000);
    wr32(5'h04, 32'h40000000);
    rd32(5'h04, 32'h40000000, 32'h0);
    wr32(5'h0c, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("irq_mask", 1'b0, irq)
    wr32(5'h0c, 32'h4);
    repeat (2) @(posedge clk);
    `CHK("irq_on", 1'b1, irq)
    wr32(5'h10, 32'h4);
    repeat (2) @(posedge clk);
    `CHK("irq_clr", 1'b0, irq)
    repeat (100) @(posedge clk);
    wr32(5'h00, 32'h00008000);
    i = 0;
    for (n = 0; n < 1200 && irq !== 1'b1; n++) begin
      @(posedge clk);
      if (dma === 1'b1)
        i++;
    end
    `CHK("early_dma", 0, i)
    waitfor(1, 200);
    wr32(5'h00, 32'h40008000);
    #1 `CHK("flush", 1'b1, fl)
    wr32(5'h00, 32'h40000000);
    wr32(5'h00, 32'h50c00000);
    wr32(5'h00, 32'h50c08000);
    repeat (20) @(posedge clk);
    `CHK("pin_oe", 2'b00, {c2e, c3e})
    // Start just after the outside field falls, so a restart opens field one
    while (c3i !== 1'b1) @(posedge clk);
    while (c3i !== 1'b0) @(posedge clk);
    repeat (20) @(posedge clk);
    wr32(5'h10, 32'h7);
    repeat (3) @(posedge clk);
    pfs <= 1'b1;
    @(posedge clk);
    pfs <= 1'b0;
    waitfor(0, 8);
    results();
  end
endmodule
`default_nettype wire
